// ### bcb_map.svh
// constants for the branch, compare and bounds unit
`ifndef BCB_MAP_SVH
`define BCB_MAP_SVH
`define WORD_W      36
`define DWORD_W     72
`define QW_W        9
`define HW_W        18
`define DISP_W      29
`define VADDR_W     32
`define ONE_WORD    36'h000000001
`define STEP_WORDS  32'h00000001
`endif

// ### bcb_pkg.sv
// types for the branch, compare and bounds unit
package bcb_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_DEC_JUMP_ZERO, OP_DEC_JUMP_ALWAYS, OP_COMPACT_JUMP, OP_GENERAL_JUMP,
        OP_CAS_FAIL, OP_CAS_SUCCESS, OP_SIGNED_CMP, OP_UNSIGNED_CMP, OP_RANGE_FLAG, OP_RANGE_TRAP
    } op_t;
    typedef enum logic [2:0] {
        COND_GREATER, COND_EQUAL, COND_GEQ, COND_LESS, COND_NEQ, COND_LEQ,
        COND_MASK_A, COND_MASK_B
    } arith_condition_t;
    typedef enum logic [1:0] {PREC_QUARTER, PREC_HALF, PREC_SINGLE, PREC_DOUBLE} prec_t;
    typedef enum logic [2:0] {BND_BOTH, BND_MIN, BND_MINUS_ONE, BND_ZERO, BND_ONE} bound_mode_t;
    typedef struct packed {
        logic             valid;
        op_t              op;
        arith_condition_t cond;
        prec_t            prec;
        bound_mode_t      bmode;
        logic [71:0]      src1;
        logic [71:0]      src2;
        logic [71:0]      third_general_register;
        logic [31:0]      pc;
        logic [31:0]      jump_target;
        logic [28:0]      disp;
        logic             src1_const;
    } issue_t;
    typedef struct packed {
        logic        valid;
        logic        pc_load;
        logic [31:0] next_pc;
        logic        wr_en;
        logic [71:0] wr_data;
        prec_t       wr_prec;
        logic        integer_overflow_flag;
        logic        bounds_trap;
        logic        illegal;
    } result_t;
endpackage

// ### branch_compare_bounds_unit.sv
// branch, compare-and-swap, compare flag and bounds check execution unit
`include "bcb_map.svh"
module branch_compare_bounds_unit
    import bcb_pkg::*;
#(
    parameter int WORD_BITS = `WORD_W,   // singleword width
    parameter int DISP_BITS = `DISP_W,   // compact jump displacement width
    parameter int ADDR_BITS = `VADDR_W   // virtual address width
)
(
    input  wire logic    clk_in,    // core clock
    input  wire logic    rst_in,    // async reset, active high
    input  wire issue_t  issue_in,  // decoded instruction with operands
    output result_t      result_out // registered result one cycle later
);
    // ==========================================
    // elaboration checks
    // the datapath is built for 36-bit words split into 9-bit quarters
    if (WORD_BITS != 36 || 2 * WORD_BITS != `DWORD_W) begin : g_word_chk
        $error("singleword width must be 36 bits");
    end
    // the wrap of the compact jump relies on a 32-bit address and 29-bit displacement
    if (DISP_BITS != 29 || ADDR_BITS != 32) begin : g_addr_chk
        $error("displacement must be 29 bits and address 32 bits");
    end

    // ==========================================
    // helpers
    function automatic logic [71:0] sext(input logic [71:0] v, input prec_t p);
        unique case (p)
            PREC_QUARTER: sext = {{63{v[8]}}, v[8:0]};
            PREC_HALF:    sext = {{54{v[17]}}, v[17:0]};
            PREC_SINGLE:  sext = {{36{v[35]}}, v[35:0]};
            PREC_DOUBLE:  sext = v;
        endcase
    endfunction
    function automatic logic [71:0] zext(input logic [71:0] v, input prec_t p);
        unique case (p)
            PREC_QUARTER: zext = {63'h0, v[8:0]};
            PREC_HALF:    zext = {54'h0, v[17:0]};
            PREC_SINGLE:  zext = {36'h0, v[35:0]};
            PREC_DOUBLE:  zext = v;
        endcase
    endfunction
    // split a double-width pair into first (high) and second (low) halves
    function automatic logic [143:0] halves(input logic [71:0] v, input prec_t p);
        unique case (p)
            PREC_QUARTER: halves = {sext({54'h0, v[17:9]}, p), sext({63'h0, v[8:0]}, p)};
            PREC_HALF:    halves = {sext({36'h0, v[35:18]}, p), sext({54'h0, v[17:0]}, p)};
            default:      halves = {sext({36'h0, v[71:36]}, PREC_SINGLE), sext(v, PREC_SINGLE)};
        endcase
    endfunction
    function automatic logic cond_hold(input arith_condition_t c, input logic lt, input logic eq);
        unique case (c)
            COND_GREATER: cond_hold = !lt && !eq;
            COND_EQUAL:   cond_hold = eq;
            COND_GEQ:     cond_hold = !lt;
            COND_LESS:    cond_hold = lt;
            COND_NEQ:     cond_hold = !eq;
            COND_LEQ:     cond_hold = lt || eq;
            default:      cond_hold = 1'b0;
        endcase
    endfunction
    function automatic logic [71:0] min_of(input prec_t p);
        unique case (p)
            PREC_QUARTER: min_of = {{63{1'b1}}, 9'h100};
            PREC_HALF:    min_of = {{54{1'b1}}, 18'h20000};
            PREC_SINGLE:  min_of = {{36{1'b1}}, 36'h800000000};
            PREC_DOUBLE:  min_of = {1'b1, 71'h0};
        endcase
    endfunction

    // ==========================================
    // datapath
    result_t           nxt_res;
    result_t           res_ff;
    logic [35:0]       dec_val;
    logic              dec_ovf;
    logic [31:0]       seq_pc;
    logic [31:0]       hop_pc;
    logic              cmp_lt;
    logic              cmp_eq;
    logic              cas_eq;
    logic              cond_ok;
    logic signed [71:0] lo_b;
    logic signed [71:0] hi_b;
    logic signed [71:0] chk_v;
    logic              in_rng;
    logic [143:0]      pair;

    always_comb begin
        dec_val = issue_in.src1[35:0] - `ONE_WORD;
        dec_ovf = issue_in.src1[35] && !dec_val[35];
        seq_pc  = issue_in.pc + `STEP_WORDS;
        hop_pc  = issue_in.pc + {3'h0, issue_in.disp};
        cas_eq  = zext(issue_in.src1, issue_in.prec) == zext(issue_in.src2, issue_in.prec);
        cmp_eq  = cas_eq;
        if (issue_in.op == OP_SIGNED_CMP)
            cmp_lt = $signed(sext(issue_in.src1, issue_in.prec)) < $signed(sext(issue_in.src2, issue_in.prec));
        else
            cmp_lt = zext(issue_in.src1, issue_in.prec) < zext(issue_in.src2, issue_in.prec);
        cond_ok = cond_hold(issue_in.cond, cmp_lt, cmp_eq);
        // a constant pair arrives as one value doubled in precision, same split
        pair  = halves(issue_in.src1, issue_in.prec);
        chk_v = $signed(sext(issue_in.src2, issue_in.prec));
        hi_b  = $signed(sext(issue_in.src1, issue_in.prec));
        unique case (issue_in.bmode)
            BND_BOTH: begin
                lo_b = $signed(pair[143:72]);
                hi_b = $signed(pair[71:0]);
            end
            BND_MIN:       lo_b = $signed(min_of(issue_in.prec));
            BND_MINUS_ONE: lo_b = -72'sd1;
            BND_ZERO:      lo_b = 72'sd0;
            BND_ONE:       lo_b = 72'sd1;
            default:       lo_b = 72'sd0;
        endcase
        in_rng = (lo_b <= chk_v) && (chk_v <= hi_b);

        nxt_res         = '0;
        nxt_res.valid   = issue_in.valid;
        nxt_res.next_pc = seq_pc;
        nxt_res.wr_prec = PREC_SINGLE;
        if (issue_in.valid) begin
            unique case (issue_in.op)
                OP_DEC_JUMP_ZERO: begin
                    nxt_res.wr_en   = 1'b1;
                    nxt_res.wr_data = {36'h0, dec_val};
                    nxt_res.integer_overflow_flag = dec_ovf;
                    // against zero: lt is the sign, eq is all zero
                    nxt_res.pc_load = 1'b1;
                    if (cond_hold(issue_in.cond, dec_val[35], dec_val == 36'h0))
                        nxt_res.next_pc = issue_in.jump_target;
                    nxt_res.illegal = issue_in.cond > COND_LEQ;
                end
                OP_DEC_JUMP_ALWAYS: begin
                    nxt_res.wr_en   = 1'b1;
                    nxt_res.wr_data = {36'h0, dec_val};
                    nxt_res.integer_overflow_flag = dec_ovf;
                    nxt_res.pc_load = 1'b1;
                    nxt_res.next_pc = issue_in.jump_target;
                end
                OP_COMPACT_JUMP: begin
                    nxt_res.pc_load = 1'b1;
                    nxt_res.next_pc = hop_pc;
                end
                OP_GENERAL_JUMP: begin
                    nxt_res.pc_load = 1'b1;
                    nxt_res.next_pc = issue_in.jump_target;
                end
                OP_CAS_FAIL, OP_CAS_SUCCESS: begin
                    // compare and write issue in the same cycle; the core holds the lock
                    nxt_res.wr_en   = cas_eq;
                    nxt_res.wr_data = zext(issue_in.third_general_register, issue_in.prec);
                    nxt_res.wr_prec = issue_in.prec;
                    nxt_res.pc_load = 1'b1;
                    if ((issue_in.op == OP_CAS_FAIL) ? !cas_eq : cas_eq)
                        nxt_res.next_pc = issue_in.jump_target;
                end
                OP_SIGNED_CMP, OP_UNSIGNED_CMP: begin
                    nxt_res.illegal = issue_in.cond > COND_LEQ;
                    nxt_res.wr_en   = !nxt_res.illegal;
                    nxt_res.wr_data = {36'h0, {36{cond_ok}}};
                end
                OP_RANGE_FLAG: begin
                    nxt_res.wr_en   = 1'b1;
                    nxt_res.wr_data = {36'h0, {36{in_rng}}};
                end
                OP_RANGE_TRAP: nxt_res.bounds_trap = !in_rng;
                default: nxt_res.illegal = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            res_ff <= '0;
        else
            res_ff <= nxt_res;
    end
    assign result_out = res_ff;

    // ==========================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    flag_all_ones_a: assert property (issue_in.valid && issue_in.op == OP_RANGE_FLAG |=>
        result_out.wr_en && result_out.wr_data[35:0] == ($past(in_rng) ? 36'hfffffffff : 36'h0))
        else $error("range flag not minus one or zero");
    flag_upper_zero_a: assert property (result_out.wr_en && result_out.wr_prec == PREC_SINGLE |->
        result_out.wr_data[71:36] == 36'h0) else $error("flag not a singleword");
    trap_no_write_a: assert property (result_out.bounds_trap |-> !result_out.wr_en)
        else $error("bounds trap wrote a result");
    dec_always_a: assert property (issue_in.valid && issue_in.op == OP_DEC_JUMP_ALWAYS |=>
        result_out.pc_load && result_out.next_pc == $past(issue_in.jump_target))
        else $error("decrement always did not jump");
    compact_target_a: assert property (issue_in.valid && issue_in.op == OP_COMPACT_JUMP |=>
        result_out.next_pc == $past(issue_in.pc) + {3'h0, $past(issue_in.disp)})
        else $error("compact jump target wrong");
    cas_fail_a: assert property (issue_in.valid && issue_in.op == OP_CAS_FAIL && !cas_eq |=>
        !result_out.wr_en && result_out.next_pc == $past(issue_in.jump_target))
        else $error("cas fail path wrong");
    cas_success_a: assert property (issue_in.valid && issue_in.op == OP_CAS_SUCCESS && !cas_eq |=>
        !result_out.wr_en && result_out.next_pc == $past(seq_pc)) else $error("cas success fall through wrong");
    dec_zero_false_a: assert property (issue_in.valid && issue_in.op == OP_DEC_JUMP_ZERO
        && issue_in.cond == COND_EQUAL && dec_val != 36'h0 |=> result_out.next_pc == $past(seq_pc))
        else $error("false decrement jump left sequence");
    ovf_only_dec_a: assert property (result_out.integer_overflow_flag |->
        result_out.wr_en && !result_out.bounds_trap) else $error("overflow from wrong op");
    mask_cond_a: assert property (issue_in.valid && issue_in.op == OP_SIGNED_CMP && issue_in.cond > COND_LEQ
        |=> result_out.illegal && !result_out.wr_en) else $error("mask condition decoded");

    // range trap: issue out of bounds, then a trap with no jump
    sequence range_trap_issue_s;
        issue_in.valid && issue_in.op == OP_RANGE_TRAP;
    endsequence
    sequence trap_raised_s;
        result_out.bounds_trap && !result_out.pc_load && !result_out.illegal;
    endsequence
    trap_raise_a: assert property (range_trap_issue_s ##0 !in_rng |=> trap_raised_s)
        else $error("range trap not raised");
    trap_quiet_a: assert property (range_trap_issue_s ##0 in_rng |=> !result_out.bounds_trap)
        else $error("range trap raised inside bounds");
    // compare flag: legal condition, then a singleword of all ones or zero
    sequence cmp_issue_s;
        issue_in.valid && (issue_in.op == OP_SIGNED_CMP || issue_in.op == OP_UNSIGNED_CMP)
            && issue_in.cond <= COND_LEQ;
    endsequence
    sequence flag_word_s;
        result_out.wr_en && result_out.wr_data[71:36] == 36'h0
            && (result_out.wr_data[35:0] == 36'hfffffffff || result_out.wr_data[35:0] == 36'h0);
    endsequence
    cmp_flag_word_a: assert property (cmp_issue_s |=> flag_word_s)
        else $error("compare flag not minus one or zero");
    cas_write_a: assert property (issue_in.valid && (issue_in.op == OP_CAS_FAIL || issue_in.op == OP_CAS_SUCCESS)
        && cas_eq |=> result_out.wr_en && result_out.wr_prec == $past(issue_in.prec))
        else $error("cas write missing or wrong precision");
    dec_ovf_a: assert property (issue_in.valid && issue_in.op == OP_DEC_JUMP_ZERO
        && issue_in.src1[35:0] == 36'h800000000 |=> result_out.integer_overflow_flag)
        else $error("decrement overflow not flagged");
    dec_zero_jump_a: assert property (issue_in.valid && issue_in.op == OP_DEC_JUMP_ZERO
        && issue_in.cond == COND_EQUAL && issue_in.src1[35:0] == 36'h1
        |=> result_out.pc_load && result_out.next_pc == $past(issue_in.jump_target))
        else $error("decrement to zero did not jump");
    unknown_op_a: assert property (issue_in.valid && issue_in.op > OP_RANGE_TRAP
        |=> result_out.illegal && !result_out.wr_en && !result_out.pc_load)
        else $error("unknown operation not refused");
    idle_quiet_a: assert property (!issue_in.valid |=> !result_out.valid && !result_out.wr_en)
        else $error("result without an issue");
endmodule

// ### branch_compare_bounds_unit_bench.sv
// self-checking bench for the branch, compare and bounds unit
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; $display("mismatch %s exp %h seen %h", nm, e, s); end end
module branch_compare_bounds_unit_bench
    import bcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        result_t    r;
        logic [4:0] care; // pc, wr, overflow, trap, illegal
    } note_t;
    logic        clk_in;
    logic        rst_in;
    issue_t      issue_in;
    result_t     result_out;
    note_t       notes[$];
    note_t       n;
    int          err_total;
    int          num_checks;
    logic [31:0] seed = 32'h8412be05;
    issue_t      i;
    branch_compare_bounds_unit dut_u (.clk_in(clk_in), .rst_in(rst_in), .issue_in(issue_in), .result_out(result_out));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // ========================================
    // models
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed;
    endfunction
    function automatic logic [71:0] msk(logic [71:0] v, int p);
        return v & ((72'h1 << (9 << p)) - 72'h1);
    endfunction
    function automatic logic signed [72:0] fit(logic [71:0] v, prec_t p, logic sgn);
        logic [72:0] t;
        int s;
        s = 73 - (9 << p);
        t = {1'b0, v} << s;
        if (sgn) fit = $signed(t) >>> s;
        else fit = t >> s;
    endfunction
    function automatic logic holds(logic signed [72:0] a, logic signed [72:0] b, arith_condition_t c);
        case (c)
            COND_GREATER: holds = a > b;
            COND_EQUAL:   holds = a == b;
            COND_GEQ:     holds = a >= b;
            COND_LESS:    holds = a < b;
            COND_NEQ:     holds = a != b;
            default:      holds = a <= b;
        endcase
    endfunction
    function automatic note_t expect_of(issue_t i);
        note_t n;
        logic signed [72:0] a, lo, hi;
        logic [35:0] d;
        logic m, eq, h;
        n = '0;
        n.r.valid = 1'b1;
        n.r.pc_load = 1'b1;
        n.r.next_pc = i.pc + 32'h1;
        n.r.wr_prec = PREC_SINGLE;
        m = i.cond inside {COND_MASK_A, COND_MASK_B};
        n.care = 5'b11001;
        eq = fit(i.src1, i.prec, 1'b0) == fit(i.src2, i.prec, 1'b0);
        a = fit(i.src2, i.prec, 1'b1);
        hi = fit(i.src1, i.prec, 1'b1);
        case (i.bmode)
            BND_BOTH: begin lo = fit(i.src1 >> (9 << i.prec), i.prec, 1'b1); end
            BND_MIN: lo = fit(72'h1 << ((9 << i.prec) - 1), i.prec, 1'b1);
            BND_MINUS_ONE: lo = -73'sd1;
            BND_ZERO: lo = 73'sd0;
            default: lo = 73'sd1;
        endcase
        h = (i.op == OP_RANGE_FLAG || i.op == OP_RANGE_TRAP) ? (lo <= a && a <= hi) : 1'b0;
        case (i.op)
            OP_DEC_JUMP_ZERO, OP_DEC_JUMP_ALWAYS: begin
                d = i.src1[35:0] - 36'h1;
                n.care = 5'b11101;
                n.r.wr_en = 1'b1;
                n.r.wr_data = {36'h0, d};
                n.r.integer_overflow_flag = i.src1[35:0] == 36'h800000000;
                if (i.op == OP_DEC_JUMP_ALWAYS || holds(fit({36'h0, d}, PREC_SINGLE, 1'b1), 73'sd0, i.cond))
                    n.r.next_pc = i.jump_target;
                if (m && i.op == OP_DEC_JUMP_ZERO) begin n.care = 5'b00001; n.r.illegal = 1'b1; end
            end
            OP_COMPACT_JUMP: begin n.care = 5'b10001; n.r.next_pc = i.pc + {3'h0, i.disp}; end
            OP_GENERAL_JUMP: begin n.care = 5'b10001; n.r.next_pc = i.jump_target; end
            OP_CAS_FAIL, OP_CAS_SUCCESS: begin
                n.r.wr_en = eq;
                n.r.wr_data = i.third_general_register;
                n.r.wr_prec = i.prec;
                if (eq == (i.op == OP_CAS_SUCCESS)) n.r.next_pc = i.jump_target;
            end
            OP_SIGNED_CMP, OP_UNSIGNED_CMP: begin
                n.care = m ? 5'b00001 : 5'b01001;
                n.r.illegal = m;
                n.r.wr_en = !m;
                h = holds(fit(i.src1, i.prec, i.op == OP_SIGNED_CMP), fit(i.src2, i.prec, i.op == OP_SIGNED_CMP), i.cond);
                n.r.wr_data = h ? 72'hfffffffff : 72'h0;
            end
            OP_RANGE_FLAG, OP_RANGE_TRAP: begin
                n.care = 5'b01011;
                n.r.wr_en = i.op == OP_RANGE_FLAG;
                n.r.wr_data = h ? 72'hfffffffff : 72'h0;
                n.r.bounds_trap = i.op == OP_RANGE_TRAP && !h;
            end
            default: begin n.care = 5'b01001; n.r.illegal = 1'b1; end
        endcase
        return n;
    endfunction
    // ========================================
    // driver and monitor
    task automatic put(op_t o, int c, int p, int b, logic [71:0] s1, logic [71:0] s2);
        i = '0;
        i.valid = 1'b1;
        i.op = o;
        i.cond = arith_condition_t'(3'(c));
        i.prec = prec_t'(2'(p));
        i.bmode = bound_mode_t'(3'(b));
        i.src1 = s1;
        i.src2 = s2;
        i.third_general_register = msk(72'({rnd(), rnd(), rnd()}), p);
        i.pc = rnd();
        i.jump_target = rnd();
        i.disp = 29'(rnd());
        // a nonzero first source asks the compact jump to wrap the address space
        if (o == OP_COMPACT_JUMP && s1 != 72'h0) begin
            i.pc = 32'hfffffff0;
            i.disp = 29'h1fffffff;
        end
        @(posedge clk_in);
        issue_in <= i;
        notes.push_back(expect_of(i));
    endtask
    always @(negedge clk_in) begin
        if (!rst_in && result_out.valid === 1'b1) begin
            if (notes.size() == 0) begin err_total++; $display("mismatch valid exp 0 seen 1"); end
            else begin
                n = notes.pop_front();
                if (n.care[4]) `CHK("next_pc", {1'b1, n.r.next_pc}, {result_out.pc_load, result_out.next_pc})
                if (n.care[3]) `CHK("write", {n.r.wr_en, n.r.wr_en ? {n.r.wr_prec, n.r.wr_data} : 74'h0}, {result_out.wr_en, result_out.wr_en ? {result_out.wr_prec, result_out.wr_data} : 74'h0})
                if (n.care[2]) `CHK("overflow", n.r.integer_overflow_flag, result_out.integer_overflow_flag)
                if (n.care[1]) `CHK("trap", n.r.bounds_trap, result_out.bounds_trap)
                if (n.care[0]) `CHK("illegal", n.r.illegal, result_out.illegal)
            end
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ========================================
    // scenarios
    initial begin
        issue_in = '0;
        rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int c = 0; c < 8; c++)
            for (int k = 0; k < 5; k++) begin
                put(OP_DEC_JUMP_ZERO, c, 2, 0, k == 4 ? 72'({rnd(), rnd()}) : 72'h800000000 >> (k * 4), 0);
                put(OP_DEC_JUMP_ALWAYS, c, 2, 0, k == 1 ? 72'h800000000 : 72'(k), 0);
            end
        put(OP_COMPACT_JUMP, 0, 2, 0, 0, 0);
        put(OP_COMPACT_JUMP, 0, 2, 0, 1, 0);
        put(OP_GENERAL_JUMP, 0, 2, 0, 0, 0);
        $display("test decrement and jumps done");
        for (int p = 0; p < 4; p++)
            for (int k = 0; k < 4; k++) begin
                put(k[0] ? OP_CAS_SUCCESS : OP_CAS_FAIL, 0, p, 0, msk(72'(k), p), msk(72'(k >> 1), p));
                for (int c = 0; c < 8; c++)
                    put(k[0] ? OP_SIGNED_CMP : OP_UNSIGNED_CMP, c, p, 0, msk({rnd(), rnd(), rnd()}, p),
                        k[1] ? msk(72'hfff000000000000000, p) : msk({rnd(), rnd(), rnd()}, p));
            end
        $display("test moves and compares done");
        for (int b = 0; b < 5; b++)
            for (int p = 0; p < 4; p++)
                for (int k = 0; k < 6; k++)
                    if (b != 0 || p != 3)
                        put(k[0] ? OP_RANGE_TRAP : OP_RANGE_FLAG, 0, p, b, msk({rnd(), rnd(), rnd()}, b == 0 ? p + 1 : p),
                            k < 2 ? msk(72'(b) - 72'h2, p) : msk({rnd(), rnd(), rnd()}, p));
        put(op_t'(4'hf), 0, 2, 0, 0, 0);
        $display("test bounds done");
        @(posedge clk_in);
        issue_in <= '0;
        @(posedge clk_in);
        @(posedge clk_in);
        rst_in <= 1'b1;
        @(negedge clk_in);
        if (notes.size() != 0) begin err_total++; $display("mismatch pending exp 0 seen %0d", notes.size()); end
        notes.delete();
        `CHK("reset", '0, result_out) // RESET
        @(posedge clk_in);
        rst_in <= 1'b0;
        put(OP_DEC_JUMP_ALWAYS, 0, 2, 0, 72'h5, 0);
        @(posedge clk_in);
        issue_in <= '0;
        for (int t = 0; t < 10 && notes.size() != 0; t++) @(posedge clk_in);
        if (notes.size() != 0) begin err_total++; $display("mismatch drain exp 0 seen %0d", notes.size()); end
        $display("test reset done");
        finish_test();
    end
endmodule
